// ---- rtl/brf_pkg.sv ----
// Constants and types shared by the banked register file and its bank mapper
`default_nettype none
package brf_pkg;

  // ==========================================================================
  // Geometry
  localparam int          BRF_GPR_PHYS    = 24;
  localparam int          BRF_FPR_PHYS    = 32;
  localparam int          BRF_FP_WORDS    = 16;
  localparam int          BRF_R15_PHYS    = 23;
  localparam logic [1:0]  BRF_SEL_BANK0   = 2'b00;
  localparam logic [1:0]  BRF_SEL_BANK1   = 2'b01;
  localparam logic [1:0]  BRF_SEL_SHARED  = 2'b10;

  // ==========================================================================
  // Status word layout
  localparam int          BRF_SW_MODE_POS = 30;
  localparam int          BRF_SW_BANK_POS = 29;
  localparam int          BRF_SW_EXCM_POS = 28;
  localparam int          BRF_SW_FPUD_POS = 15;
  localparam int          BRF_SW_IM_LSB   = 4;
  localparam int          BRF_SW_IM_MSB   = 7;
  localparam logic [31:0] BRF_SW_RESET    = 32'h700000F0;
  localparam logic [31:0] BRF_SW_EXC_SET  = 32'h70000000;
  localparam logic [31:0] BRF_SW_PRIV_MSK = 32'h700080F0;
  localparam logic [31:0] BRF_SW_USER_MSK = 32'h00000303;
  localparam logic [31:0] BRF_SW_WR_MSK   = 32'h700083F3;

  // ==========================================================================
  // Reset values and floating-point control layout
  localparam logic [31:0] BRF_VBASE_RESET = 32'h00000000;
  localparam logic [31:0] BRF_PC_RESET    = 32'h0A000000;
  localparam logic [31:0] BRF_FPSC_RESET  = 32'h00040001;
  localparam logic [31:0] BRF_ZERO        = 32'h00000000;
  localparam int          BRF_FPSC_BK_POS = 21;

  // ==========================================================================
  // Control and system register selects
  typedef enum logic [3:0] {
    BRF_CR_GLOBAL_BASE  = 4'h0,
    BRF_CR_STATUS_WORD  = 4'h1,
    BRF_CR_SAVED_STATUS = 4'h2,
    BRF_CR_SAVED_PROG   = 4'h3,
    BRF_CR_VECTOR_BASE  = 4'h4,
    BRF_CR_SAVED_STACK  = 4'h5,
    BRF_CR_DEBUG_BASE   = 4'h6,
    BRF_CR_MAC_HIGH     = 4'h7,
    BRF_CR_MAC_LOW      = 4'h8,
    BRF_CR_SUB_LINK     = 4'h9,
    BRF_CR_PROG_CTR     = 4'hA,
    BRF_CR_FP_STATUS    = 4'hB,
    BRF_CR_FP_TRANSFER  = 4'hC
  } brf_creg_t;

  // Floating-point read views
  typedef enum logic [1:0] {
    BRF_FV_SINGLE = 2'h0,
    BRF_FV_PAIR   = 2'h1,
    BRF_FV_VECTOR = 2'h2,
    BRF_FV_MATRIX = 2'h3
  } brf_fview_t;

  // Registers that only privileged code may touch
  function automatic logic brf_priv_only(input brf_creg_t s);
    return (s == BRF_CR_SAVED_STATUS) || (s == BRF_CR_SAVED_PROG) ||
           (s == BRF_CR_VECTOR_BASE)  || (s == BRF_CR_SAVED_STACK) ||
           (s == BRF_CR_DEBUG_BASE);
  endfunction : brf_priv_only

endpackage : brf_pkg
`default_nettype wire

// ---- rtl/brf_map_if.sv ----
// Carrier between the register file and one general register bank mapper
`timescale 1ns/1ps
`default_nettype none
interface brf_map_if;
  logic       priv;
  logic       bank;
  logic       alt;
  logic [3:0] vis;
  logic [4:0] phys;
  logic       blocked;
  modport user   (output priv, bank, alt, vis, input phys, blocked);
  modport mapper (input priv, bank, alt, vis, output phys, blocked);
endinterface : brf_map_if
`default_nettype wire

// ---- rtl/brf_gpr_map.sv ----
// Maps a visible general register number onto the physical banked array
`timescale 1ns/1ps
`default_nettype none
module brf_gpr_map
  import brf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  brf_map_if.mapper m
);

  // ==========================================================================
  // Bank choice
  logic use_bank1;

  // Alternate access flips the bank; only privileged code may ask for it
  assign use_bank1 = m.priv & (m.bank ^ m.alt);
  assign m.blocked = m.alt & ~m.priv;

  // Upper eight always land in the one shared set
  always_comb begin
    if (m.vis[3]) begin
      m.phys = {BRF_SEL_SHARED, m.vis[2:0]};
    end else if (use_bank1) begin
      m.phys = {BRF_SEL_BANK1, m.vis[2:0]};
    end else begin
      m.phys = {BRF_SEL_BANK0, m.vis[2:0]};
    end
  end

  // ==========================================================================
  // Checks
  a_shared_upper_map: assert property (
    @(posedge clk) disable iff (!rst_n)
    m.vis[3] |-> (m.phys == {BRF_SEL_SHARED, m.vis[2:0]}))
    else $error("upper register not in shared set");

  a_user_bank_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!m.priv && !m.vis[3]) |-> (m.phys[4:3] == BRF_SEL_BANK0))
    else $error("user mode reached bank one");

  a_priv_bank_one: assert property (
    @(posedge clk) disable iff (!rst_n)
    (m.priv && m.bank && !m.alt && !m.vis[3]) |-> (m.phys[4:3] == BRF_SEL_BANK1))
    else $error("bank one not visible with bank select set");

  a_priv_bank_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (m.priv && !m.bank && !m.vis[3]) |-> (m.phys[4:3] == (m.alt ? BRF_SEL_BANK1 : BRF_SEL_BANK0)))
    else $error("wrong bank with bank select clear");

endmodule : brf_gpr_map
`default_nettype wire

// ---- rtl/brf_regfile.sv ----
// Banked processor register file: general, control, system and floating-point
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Runs in user mode; exception or accepted interrupt switches to privileged mode.
// - Sixteen visible general registers; the lower eight switch with mode and bank.
// - Privileged, bank select 1: low eight are bank one; alternate access reaches zero.
// - Privileged, bank select 0: low eight are bank zero; alternate access reaches one.
// - User mode sees bank zero plus shared eight; bank one is unreachable.
// - Global base and status in both modes; saved and base registers privileged only.
// - Privileged status bits, bank select among them, change only in privileged mode.
// - Multiply-accumulate, link, program counter and FP registers need no privilege.
// - Thirty-two FP registers as primary and extended sets over two banks.
// - Primary set readable as pairs or vectors; extended as pairs or matrix.
// - Status resets with mode, bank select, exception mask set, mask field all ones.
// - Reset loads vector base zero, program counter and FP control fixed values.
// - The mode bit in the status word selects user or privileged mode.
// - General register zero is presented as the index operand.
// - After an exception or interrupt the low eight map to bank one.
// - FP bank select 0 gives primary bank zero; 1 swaps; extended takes the other.
module brf_regfile
  import brf_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [3:0]   gpr_ra_idx,
  input  wire logic         gpr_ra_alt,
  input  wire logic [3:0]   gpr_rb_idx,
  output logic      [31:0]  gpr_ra_data,
  output logic      [31:0]  gpr_rb_data,
  output logic      [31:0]  gpr0_index,
  input  wire logic         gpr_we,
  input  wire logic [3:0]   gpr_wr_idx,
  input  wire logic         gpr_wr_alt,
  input  wire logic [31:0]  gpr_wr_data,
  output logic              gpr_viol,
  input  wire logic         creg_req,
  input  wire logic         creg_we,
  input  wire brf_creg_t    creg_sel,
  input  wire logic [31:0]  creg_wdata,
  output logic      [31:0]  creg_rdata,
  output logic              creg_viol,
  input  wire logic         pc_we,
  input  wire logic [31:0]  pc_wdata,
  output logic      [31:0]  prog_ctr,
  input  wire logic         exc_take,
  input  wire logic [31:0]  exc_offset,
  input  wire logic         exc_return,
  input  wire logic         fp_rd_ext,
  input  wire logic [3:0]   fp_rd_idx,
  input  wire brf_fview_t   fp_rd_view,
  output logic      [511:0] fp_rdata,
  input  wire logic         fp_we,
  input  wire logic         fp_wr_ext,
  input  wire logic [3:0]   fp_wr_idx,
  input  wire logic         fp_wr_pair,
  input  wire logic [63:0]  fp_wr_data,
  output logic              privilege_mode_bit,
  output logic              bank_select_bit,
  output logic              exception_mask_bit,
  output logic              fpu_disable_bit,
  output logic      [3:0]   int_mask_field,
  output logic              fp_bank_select
);

  // ==========================================================================
  // Storage
  logic [31:0] gpr_q [BRF_GPR_PHYS];
  logic [31:0] fpr_q [BRF_FPR_PHYS];
  logic [31:0] status_q, ssr_q, spc_q, sgr_q, gbr_q, vbr_q, dbr_q;
  logic [31:0] multiply_acc_high_q, multiply_acc_low_q, link_q, pc_q, fpsc_q, fp_transfer_reg_q;
  logic [31:0] creg_rdata_d, status_rd;
  logic [511:0] fp_rd_d;
  logic        priv, status_bad, creg_wr, ra_block, wr_block;

  brf_map_if m_ra ();
  brf_map_if m_rb ();
  brf_map_if m_wr ();

  // Mode and bank come straight from the status word
  assign priv               = status_q[BRF_SW_MODE_POS];
  assign privilege_mode_bit = priv;
  assign bank_select_bit    = status_q[BRF_SW_BANK_POS];
  assign exception_mask_bit = status_q[BRF_SW_EXCM_POS];
  assign fpu_disable_bit    = status_q[BRF_SW_FPUD_POS];
  assign int_mask_field     = status_q[BRF_SW_IM_MSB:BRF_SW_IM_LSB];
  assign fp_bank_select     = fpsc_q[BRF_FPSC_BK_POS];
  assign prog_ctr           = pc_q;

  // ==========================================================================
  // General register bank mapping
  assign m_ra.priv = priv;
  assign m_ra.bank = bank_select_bit;
  assign m_ra.alt  = gpr_ra_alt;
  assign m_ra.vis  = gpr_ra_idx;
  assign m_rb.priv = priv;
  assign m_rb.bank = bank_select_bit;
  assign m_rb.alt  = 1'b0;
  assign m_rb.vis  = gpr_rb_idx;
  assign m_wr.priv = priv;
  assign m_wr.bank = bank_select_bit;
  assign m_wr.alt  = gpr_wr_alt;
  assign m_wr.vis  = gpr_wr_idx;

  brf_gpr_map u_map_ra (.clk(clk), .rst_n(rst_n), .m(m_ra));
  brf_gpr_map u_map_rb (.clk(clk), .rst_n(rst_n), .m(m_rb));
  brf_gpr_map u_map_wr (.clk(clk), .rst_n(rst_n), .m(m_wr));

  // Alternate-bank requests from user code are refused and flagged
  assign ra_block = m_ra.blocked;
  assign wr_block = gpr_we & m_wr.blocked;
  assign gpr_viol = ra_block | wr_block;

  // Contents are left uninitialised; software must write before reading
  always_ff @(posedge clk) begin
    if (gpr_we && !m_wr.blocked) begin
      gpr_q[m_wr.phys] <= gpr_wr_data;
    end
  end

  // Registered read ports; a refused read returns zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gpr_ra_data <= BRF_ZERO;
      gpr_rb_data <= BRF_ZERO;
      gpr0_index  <= BRF_ZERO;
    end else begin
      gpr_ra_data <= ra_block ? BRF_ZERO : gpr_q[m_ra.phys];
      gpr_rb_data <= gpr_q[m_rb.phys];
      gpr0_index  <= gpr_q[{(bank_select_bit & priv) ? BRF_SEL_BANK1 : BRF_SEL_BANK0,
                            3'h0}];
    end
  end

  // ==========================================================================
  // Control and system register access checks
  assign status_bad = creg_we && (creg_sel == BRF_CR_STATUS_WORD) &&
                      (((creg_wdata ^ status_q) & BRF_SW_PRIV_MSK) != BRF_ZERO);
  assign creg_viol  = creg_req & ~priv &
                      (brf_priv_only(creg_sel) | status_bad);
  assign creg_wr    = creg_req & creg_we & ~creg_viol;
  // User code sees privileged status bits as zero
  assign status_rd  = priv ? status_q : (status_q & ~BRF_SW_PRIV_MSK);

  // Read mux; system registers never depend on mode
  always_comb begin
    case (creg_sel)
      BRF_CR_GLOBAL_BASE:  creg_rdata_d = gbr_q;
      BRF_CR_STATUS_WORD:  creg_rdata_d = status_rd;
      BRF_CR_SAVED_STATUS: creg_rdata_d = ssr_q;
      BRF_CR_SAVED_PROG:   creg_rdata_d = spc_q;
      BRF_CR_VECTOR_BASE:  creg_rdata_d = vbr_q;
      BRF_CR_SAVED_STACK:  creg_rdata_d = sgr_q;
      BRF_CR_DEBUG_BASE:   creg_rdata_d = dbr_q;
      BRF_CR_MAC_HIGH:     creg_rdata_d = multiply_acc_high_q;
      BRF_CR_MAC_LOW:      creg_rdata_d = multiply_acc_low_q;
      BRF_CR_SUB_LINK:     creg_rdata_d = link_q;
      BRF_CR_PROG_CTR:     creg_rdata_d = pc_q;
      BRF_CR_FP_STATUS:    creg_rdata_d = fpsc_q;
      BRF_CR_FP_TRANSFER:  creg_rdata_d = fp_transfer_reg_q;
      default:             creg_rdata_d = BRF_ZERO;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      creg_rdata <= BRF_ZERO;
    end else begin
      creg_rdata <= (creg_req && !creg_viol) ? creg_rdata_d : BRF_ZERO;
    end
  end

  // ==========================================================================
  // Status word: exception entry beats return, return beats a write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= BRF_SW_RESET;
    end else if (exc_take) begin
      status_q <= status_q | BRF_SW_EXC_SET;
    end else if (exc_return) begin
      status_q <= ssr_q & BRF_SW_WR_MSK;
    end else if (creg_wr && creg_sel == BRF_CR_STATUS_WORD) begin
      status_q <= priv ? (creg_wdata & BRF_SW_WR_MSK) :
                  ((status_q & ~BRF_SW_USER_MSK) | (creg_wdata & BRF_SW_USER_MSK));
    end
  end

  // Save state on exception entry so the handler can return
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ssr_q <= BRF_ZERO;
      spc_q <= BRF_ZERO;
      sgr_q <= BRF_ZERO;
    end else if (exc_take) begin
      ssr_q <= status_q;
      spc_q <= pc_q;
      sgr_q <= gpr_q[BRF_R15_PHYS];
    end else if (creg_wr) begin
      if (creg_sel == BRF_CR_SAVED_STATUS) ssr_q <= creg_wdata;
      if (creg_sel == BRF_CR_SAVED_PROG)   spc_q <= creg_wdata;
      if (creg_sel == BRF_CR_SAVED_STACK)  sgr_q <= creg_wdata;
    end
  end

  // Plain control and system registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vbr_q  <= BRF_VBASE_RESET;
      fpsc_q <= BRF_FPSC_RESET;
      gbr_q  <= BRF_ZERO;
      dbr_q  <= BRF_ZERO;
      multiply_acc_high_q <= BRF_ZERO;
      multiply_acc_low_q <= BRF_ZERO;
      link_q <= BRF_ZERO;
      fp_transfer_reg_q <= BRF_ZERO;
    end else if (creg_wr) begin
      if (creg_sel == BRF_CR_VECTOR_BASE) vbr_q  <= creg_wdata;
      if (creg_sel == BRF_CR_FP_STATUS)   fpsc_q <= creg_wdata;
      if (creg_sel == BRF_CR_GLOBAL_BASE) gbr_q  <= creg_wdata;
      if (creg_sel == BRF_CR_DEBUG_BASE)  dbr_q  <= creg_wdata;
      if (creg_sel == BRF_CR_MAC_HIGH)    multiply_acc_high_q <= creg_wdata;
      if (creg_sel == BRF_CR_MAC_LOW)     multiply_acc_low_q <= creg_wdata;
      if (creg_sel == BRF_CR_SUB_LINK)    link_q <= creg_wdata;
      if (creg_sel == BRF_CR_FP_TRANSFER) fp_transfer_reg_q <= creg_wdata;
    end
  end

  // Program counter: vector on exception, restore on return
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_q <= BRF_PC_RESET;
    end else if (exc_take) begin
      pc_q <= vbr_q + exc_offset;
    end else if (exc_return) begin
      pc_q <= spc_q;
    end else if (creg_wr && creg_sel == BRF_CR_PROG_CTR) begin
      pc_q <= creg_wdata;
    end else if (pc_we) begin
      pc_q <= pc_wdata;
    end
  end

  // ==========================================================================
  // Floating-point registers; extended set always takes the opposite bank
  always_ff @(posedge clk) begin
    if (fp_we && fp_wr_pair) begin
      fpr_q[{fp_wr_ext ^ fp_bank_select, fp_wr_idx[3:1], 1'b0}] <= fp_wr_data[63:32];
      fpr_q[{fp_wr_ext ^ fp_bank_select, fp_wr_idx[3:1], 1'b1}] <= fp_wr_data[31:0];
    end else if (fp_we) begin
      fpr_q[{fp_wr_ext ^ fp_bank_select, fp_wr_idx}] <= fp_wr_data[31:0];
    end
  end

  // Lowest-numbered word lands highest, so a pair reads as {even, odd}
  always_comb begin
    logic [3:0] base;
    logic       rbank;
    int         n;
    base    = fp_rd_idx;
    n       = 1;
    rbank   = fp_rd_ext ^ fp_bank_select;
    fp_rd_d = '0;
    case (fp_rd_view)
      BRF_FV_SINGLE: n = 1;
      BRF_FV_PAIR:   begin
        n    = 2;
        base = {fp_rd_idx[3:1], 1'b0};
      end
      BRF_FV_VECTOR: begin
        n    = 4;
        base = {fp_rd_idx[3:2], 2'b00};
      end
      BRF_FV_MATRIX: begin
        n     = BRF_FP_WORDS;
        base  = 4'h0;
        rbank = ~fp_bank_select; // Matrix exists only over the extended set
      end
      default:       n = 1;
    endcase
    for (int k = 0; k < BRF_FP_WORDS; k++) begin
      if (k < n) begin
        fp_rd_d[32*(n-1-k) +: 32] = fpr_q[{rbank, 4'(base + 4'(k))}];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fp_rdata <= '0;
    end else begin
      fp_rdata <= fp_rd_d;
    end
  end

  // ==========================================================================
  // Checks
  a_exc_enters_priv: assert property (
    @(posedge clk) disable iff (!rst_n)
    exc_take |=> (privilege_mode_bit && bank_select_bit && exception_mask_bit))
    else $error("exception did not enter privileged bank one");

  a_reset_status_val: assert property (
    @(posedge clk) !rst_n |=> (status_q == BRF_SW_RESET && int_mask_field == 4'hF))
    else $error("status word reset value wrong");

  a_reset_fixed_vals: assert property (
    @(posedge clk) !rst_n |=> (pc_q == BRF_PC_RESET && vbr_q == BRF_VBASE_RESET &&
                               fpsc_q == BRF_FPSC_RESET))
    else $error("fixed reset values wrong");

  a_priv_only_block: assert property (
    @(posedge clk) disable iff (!rst_n)
    (creg_req && !priv && brf_priv_only(creg_sel)) |-> creg_viol ##1 (creg_rdata == BRF_ZERO))
    else $error("user reached a privileged register");

  a_status_bits_held: assert property (
    @(posedge clk) disable iff (!rst_n)
    (creg_req && creg_we && !priv && creg_sel == BRF_CR_STATUS_WORD && !exc_take && !exc_return)
    |=> $stable(status_q & BRF_SW_PRIV_MSK))
    else $error("user changed a privileged status bit");

  a_system_any_mode: assert property (
    @(posedge clk) disable iff (!rst_n)
    (creg_req && (creg_sel inside {BRF_CR_MAC_HIGH, BRF_CR_MAC_LOW, BRF_CR_SUB_LINK,
      BRF_CR_PROG_CTR, BRF_CR_FP_STATUS, BRF_CR_FP_TRANSFER})) |-> !creg_viol)
    else $error("system register refused");

  a_alt_user_block: assert property (
    @(posedge clk) disable iff (!rst_n)
    (gpr_ra_alt && !priv) |-> gpr_viol ##1 (gpr_ra_data == BRF_ZERO))
    else $error("user alternate bank read not refused");

  a_exc_vectors_pc: assert property (
    @(posedge clk) disable iff (!rst_n)
    exc_take |=> (pc_q == $past(vbr_q) + $past(exc_offset) && spc_q == $past(pc_q)))
    else $error("exception entry did not vector");

  c_exc_and_return: cover property (@(posedge clk) disable iff (!rst_n)
    exc_take ##[1:20] exc_return);
  c_user_violation: cover property (@(posedge clk) disable iff (!rst_n)
    creg_req && creg_viol);
  c_priv_alt_write: cover property (@(posedge clk) disable iff (!rst_n)
    gpr_we && gpr_wr_alt && priv);
  c_matrix_read: cover property (@(posedge clk) disable iff (!rst_n)
    fp_rd_view == BRF_FV_MATRIX && fp_bank_select);

endmodule : brf_regfile
`default_nettype wire

// ---- testbench/brf_pipe_model.sv ----
// Pipeline-side model that raises exception requests into the register file
`timescale 1ns/1ps
`default_nettype none
module brf_pipe_model #(
  parameter logic [31:0] EXC_OFS = 32'h00000100
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        go,
  output var  logic        exc_take,
  output logic      [31:0] exc_offset
);
  // ==========================================================================
  // Exception pulse
  // Fixed offset keeps the expected vector address easy to reckon
  assign exc_offset = EXC_OFS;
  // One-cycle pulse per request; a held go retriggers it every other cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exc_take <= 1'b0;
    end else begin
      exc_take <= go & ~exc_take;
    end
  end
endmodule : brf_pipe_model
`default_nettype wire

// ---- testbench/banked_cpu_register_file_tb.sv ----
// Self-checking bench for the banked register file
`timescale 1ns/1ps
`default_nettype none
module banked_cpu_register_file_tb;
  import brf_pkg::*;
  // ==========================================================================
  // Signals
  logic clk, rst_n, gpr_ra_alt, gpr_we, gpr_wr_alt, gpr_viol, creg_req, creg_we;
  logic creg_viol, pc_we, exc_take, exc_return, fp_rd_ext, fp_we, fp_wr_ext;
  logic fp_wr_pair, privilege_mode_bit, bank_select_bit, exception_mask_bit;
  logic fpu_disable_bit, fp_bank_select, go;
  logic [3:0] gpr_ra_idx, gpr_rb_idx, gpr_wr_idx, fp_rd_idx, fp_wr_idx, int_mask_field;
  logic [31:0] gpr_ra_data, gpr_rb_data, gpr0_index, gpr_wr_data, creg_wdata;
  logic [31:0] creg_rdata, pc_wdata, prog_ctr, exc_offset;
  logic [63:0] fp_wr_data;
  logic [511:0] fp_rdata;
  brf_creg_t creg_sel;
  brf_fview_t fp_rd_view;
  int n_errors, compares;
  // ==========================================================================
  // Instances
  brf_regfile i_dut (.clk, .rst_n, .gpr_ra_idx, .gpr_ra_alt, .gpr_rb_idx, .gpr_ra_data,
    .gpr_rb_data, .gpr0_index, .gpr_we, .gpr_wr_idx, .gpr_wr_alt, .gpr_wr_data, .gpr_viol,
    .creg_req, .creg_we, .creg_sel, .creg_wdata, .creg_rdata, .creg_viol, .pc_we, .pc_wdata,
    .prog_ctr, .exc_take, .exc_offset, .exc_return, .fp_rd_ext, .fp_rd_idx, .fp_rd_view,
    .fp_rdata, .fp_we, .fp_wr_ext, .fp_wr_idx, .fp_wr_pair, .fp_wr_data, .privilege_mode_bit,
    .bank_select_bit, .exception_mask_bit, .fpu_disable_bit, .int_mask_field, .fp_bank_select);
  brf_pipe_model i_pipe (.clk, .rst_n, .go, .exc_take, .exc_offset);
  // Clock at 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==========================================================================
  // Tasks
  task automatic close_out;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic gw(input logic [3:0] i, input logic a, input logic [31:0] d);
    @(posedge clk);
    gpr_we <= 1'b1;
    gpr_wr_idx <= i;
    gpr_wr_alt <= a;
    gpr_wr_data <= d;
    @(posedge clk);
    gpr_we <= 1'b0;
  endtask : gw
  // Read port A; the flag is combinational, data one cycle later
  task automatic gr(input logic [3:0] i, input logic a, input logic [31:0] e, input logic v);
    @(posedge clk);
    gpr_ra_idx <= i;
    gpr_ra_alt <= a;
    #1 chk({31'h0, gpr_viol}, {31'h0, v});
    @(posedge clk);
    gpr_ra_alt <= 1'b0;
    #1 chk(gpr_ra_data, e);
  endtask : gr
  task automatic ca(input brf_creg_t s, input logic w, input logic [31:0] d,
                    input logic [31:0] e, input logic v);
    @(posedge clk);
    creg_req <= 1'b1;
    creg_we <= w;
    creg_sel <= s;
    creg_wdata <= d;
    #1 chk({31'h0, creg_viol}, {31'h0, v});
    @(posedge clk);
    creg_req <= 1'b0;
    creg_we <= 1'b0;
    #1 if (!w) chk(creg_rdata, e);
  endtask : ca
  // ==========================================================================
  // Watchdog far beyond the fewer than one hundred cycles the tests need
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
  // Main sequence
  initial begin
    {rst_n, gpr_ra_alt, gpr_we, gpr_wr_alt, creg_req, creg_we, pc_we, exc_return} = '0;
    {fp_rd_ext, fp_we, fp_wr_ext, fp_wr_pair, go} = '0;
    {gpr_ra_idx, gpr_rb_idx, gpr_wr_idx, fp_rd_idx, fp_wr_idx} = '0;
    {gpr_wr_data, creg_wdata, pc_wdata, fp_wr_data} = '0;
    creg_sel = BRF_CR_GLOBAL_BASE;
    fp_rd_view = BRF_FV_SINGLE;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({28'h0, privilege_mode_bit, bank_select_bit, exception_mask_bit,
            fpu_disable_bit}, 32'hE);
    chk({27'h0, int_mask_field, fp_bank_select}, 32'h1E);
    chk(prog_ctr, BRF_PC_RESET);
    ca(BRF_CR_VECTOR_BASE, 1'b0, '0, BRF_VBASE_RESET, 1'b0);
    ca(BRF_CR_FP_STATUS, 1'b0, '0, BRF_FPSC_RESET, 1'b0);
    // Privileged, bank one visible; alternate reaches bank zero
    gw(4'h3, 1'b0, 32'hAAAA0001);
    gw(4'h3, 1'b1, 32'hBBBB0002);
    gw(4'h9, 1'b0, 32'h99990009);
    gr(4'h3, 1'b0, 32'hAAAA0001, 1'b0);
    gr(4'h3, 1'b1, 32'hBBBB0002, 1'b0);
    // Clear the bank select: bank zero visible, bank one alternate
    ca(BRF_CR_STATUS_WORD, 1'b1, 32'h500000F0, '0, 1'b0);
    gr(4'h3, 1'b0, 32'hBBBB0002, 1'b0);
    gr(4'h3, 1'b1, 32'hAAAA0001, 1'b0);
    // Drop to user mode through the mode bit
    ca(BRF_CR_STATUS_WORD, 1'b1, 32'h100000F0, '0, 1'b0);
    #1 chk({31'h0, privilege_mode_bit}, 32'h0);
    gr(4'h3, 1'b0, 32'hBBBB0002, 1'b0);
    gr(4'h3, 1'b1, 32'h0, 1'b1);
    gr(4'h9, 1'b0, 32'h99990009, 1'b0);
    ca(BRF_CR_VECTOR_BASE, 1'b0, '0, 32'h0, 1'b1);
    ca(BRF_CR_STATUS_WORD, 1'b1, 32'h700000F0, '0, 1'b1);
    ca(BRF_CR_MAC_HIGH, 1'b1, 32'h12345678, '0, 1'b0);
    ca(BRF_CR_MAC_HIGH, 1'b0, '0, 32'h12345678, 1'b0);
    ca(BRF_CR_GLOBAL_BASE, 1'b1, 32'h0000C0DE, '0, 1'b0);
    ca(BRF_CR_GLOBAL_BASE, 1'b0, '0, 32'h0000C0DE, 1'b0);
    gw(4'h0, 1'b0, 32'hC0C00000);
    repeat (2) @(posedge clk);
    #1 chk(gpr0_index, 32'hC0C00000);
    chk(gpr_rb_data, 32'hC0C00000);
    // Refused user write must leave bank one untouched
    gw(4'h3, 1'b1, 32'hDEAD0003);
    // Exception from user mode
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({29'h0, privilege_mode_bit, bank_select_bit, exception_mask_bit}, 32'h7);
    chk(prog_ctr, 32'h00000100);
    gr(4'h3, 1'b0, 32'hAAAA0001, 1'b0);
    ca(BRF_CR_SAVED_STATUS, 1'b0, '0, 32'h100000F0, 1'b0);
    // Floating-point pair written and read back as a pair
    @(posedge clk);
    fp_we <= 1'b1;
    fp_wr_idx <= 4'h4;
    fp_wr_pair <= 1'b1;
    fp_wr_data <= 64'h11112222_33334444;
    @(posedge clk);
    fp_we <= 1'b0;
    fp_rd_idx <= 4'h5;
    fp_rd_view <= BRF_FV_PAIR;
    @(posedge clk);
    #1 chk(fp_rdata[63:32], 32'h11112222);
    chk(fp_rdata[31:0], 32'h33334444);
    chk({31'h0, |fp_rdata[511:64]}, 32'h0);
    // Vector view over the same words
    fp_rd_idx <= 4'h6;
    fp_rd_view <= BRF_FV_VECTOR;
    @(posedge clk);
    #1 chk(fp_rdata[127:96], 32'h11112222);
    chk(fp_rdata[95:64], 32'h33334444);
    // Swap the FP banks: extended set now lands on the written bank
    ca(BRF_CR_FP_STATUS, 1'b1, 32'h00240001, '0, 1'b0);
    chk({31'h0, fp_bank_select}, 32'h1);
    fp_rd_view <= BRF_FV_MATRIX;
    @(posedge clk);
    #1 chk(fp_rdata[383:352], 32'h11112222);
    fp_rd_ext <= 1'b1;
    fp_rd_idx <= 4'h5;
    fp_rd_view <= BRF_FV_SINGLE;
    @(posedge clk);
    #1 chk(fp_rdata[31:0], 32'h33334444);
    // Return from the handler restores user mode and the saved counter
    exc_return <= 1'b1;
    @(posedge clk);
    exc_return <= 1'b0;
    #1 chk({31'h0, privilege_mode_bit}, 32'h0);
    chk(prog_ctr, BRF_PC_RESET);
    pc_we <= 1'b1;
    pc_wdata <= 32'h00004000;
    @(posedge clk);
    pc_we <= 1'b0;
    #1 chk(prog_ctr, 32'h00004000);
    close_out();
  end
endmodule : banked_cpu_register_file_tb
`default_nettype wire
